// >>> design/ifs_pkg.sv
// Types shared by the inverter fault supervisor
package ifs_pkg;
    typedef enum logic [1:0] {
        IFS_CLS_NONE,
        IFS_CLS_SIGNAL,
        IFS_CLS_SELFACK,
        IFS_CLS_DEACT
    } ifs_class_t;

    typedef struct packed {
        logic ac_output_contactor_closed;
        logic dc_load_switch_closed;
    } ifs_switch_t;

    typedef struct packed {
        logic deact;
        logic selfack;
        logic signal;
        logic permanent;
    } ifs_display_t;
endpackage

// >>> design/ifs_regs.svh
// Constants for the inverter fault supervisor
`ifndef IFS_REGS_SVH
`define IFS_REGS_SVH
`define IFS_MAX_RETRIES 2'h3
`define IFS_RESTART_DELAY_MS 1000
`define IFS_CLEAR_TIME_MS 60000
`define IFS_CLK_HZ 125000000
`define IFS_TICK_DIV (`IFS_CLK_HZ / 1000)
`define IFS_NUM_TEMP 21
`define IFS_NUM_CANIO 17
`endif

// >>> design/ifs_sticky.sv
// Latched fault class flags with manual acknowledge and re-raise
module ifs_sticky #(
    parameter int N = 3
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [N-1:0] cause,
    input wire logic [N-1:0] auto_clear,
    input wire logic manual_ack,
    output logic [N-1:0] flag
);
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_flag
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    flag[i] <= 1'b0;
                end else if (cause[i]) begin
                    flag[i] <= 1'b1;
                end else if (manual_ack || auto_clear[i]) begin
                    flag[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule

// >>> design/ifs_supervisor.sv
// Inverter fault supervisor: classes faults and drives contactor and load switch
// Notes on behaviour
// - Faults reported only while inverter switched on, except hardware overload, which still reports deactivating when off.
// - First deactivating fault: wait delay, auto acknowledge, attempt start-up.
// - Skip auto restart if DC voltage dipped too far during fault.
// - Persisting deactivating cause after restart trips again, opening both switches.
// - At most three automatic start-up attempts, counted.
// - Retry counter cleared after a period of continuous successful operation.
// - Last failed attempt latches a permanent shutdown.
// - Latch cleared only by power cycle, inverter switch-off or manual ack; persisting cause re-raises.
// - Hardware overload opens both DC load switch and AC contactor.
// - Self-acknowledging fault opens AC contactor, keeps DC load switch closed.
// - Self-acknowledging fault restarts once its cause is gone.
// - Self-acknowledging fault clears on ack, re-raised if cause persists.
// - Signaling fault leaves both switches closed and sequence untouched.
// - Signaling fault self-clears; ack also clears; persisting cause re-raises.
// - Stack temperature warnings signal, stack temperature faults self-acknowledge.
// - Air warnings and undertemperatures signal; air temperature faults self-acknowledge.
// - Sensor failures self-acknowledge, except unit supply air sensor, which signals.
// - Stack differential current deviation is signaling only.
// - Remote I/O feedback, breakers, disconnectors, door, node loss are signaling.
// - Insulation input: warning signals, alarm self-acknowledges, alarm deactivates.
`include "ifs_regs.svh"
module ifs_supervisor #(
    parameter int RESTART_DELAY_MS = `IFS_RESTART_DELAY_MS,
    parameter int CLEAR_TIME_MS = `IFS_CLEAR_TIME_MS,
    parameter int TICK_DIV = `IFS_TICK_DIV
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic inverter_on,
    input wire logic manual_ack,
    input wire logic [1:0] stack_temp_warn,
    input wire logic [1:0] stack_temp_fault,
    input wire logic igbt_air_under,
    input wire logic igbt_air_warn,
    input wire logic igbt_air_fault,
    input wire logic [1:0] exhaust_air_warn,
    input wire logic [1:0] exhaust_air_fault,
    input wire logic unit_air_under,
    input wire logic unit_air_warn,
    input wire logic unit_air_fault,
    input wire logic [4:0] sensor_fail,
    input wire logic unit_air_sensor_fail,
    input wire logic diff_current_dev,
    input wire logic [12:0] canio_signal,
    input wire logic canio_param_err,
    input wire logic insul_warn,
    input wire logic insul_alarm_selfack,
    input wire logic insul_alarm_deact,
    input wire logic deact_cause_ext,
    input wire logic selfack_cause_ext,
    input wire logic signal_cause_ext,
    input wire logic hw_overload,
    input wire logic dc_dip_exceeded,
    output ifs_pkg::ifs_switch_t switches,
    output ifs_pkg::ifs_display_t operator_display_unit,
    output logic [1:0] retry_count,
    output ifs_pkg::ifs_class_t active_class
);
    typedef enum logic [2:0] {
        IFS_ST_RUN,
        IFS_ST_WAIT,
        IFS_ST_ATTEMPT,
        IFS_ST_PERM
    } ifs_state_t;

    ifs_state_t state_r;
    logic tick;
    logic [31:0] delay_r;
    logic [31:0] run_r;
    logic [1:0] retry_r;
    logic dip_r;
    logic sig_cause;
    logic sack_cause;
    logic deact_cause;
    logic [2:0] causes;
    logic [2:0] flags;
    logic ack_d;
    logic ack_pulse;

    ifs_tick #(
        .DIV(TICK_DIV)
    ) u_tick (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .tick(tick)
    );

    // Classification of monitored conditions
    always_comb begin
        sig_cause = |stack_temp_warn;
        sig_cause = sig_cause | igbt_air_under | igbt_air_warn | (|exhaust_air_warn);
        sig_cause = sig_cause | unit_air_under | unit_air_warn;
        sig_cause = sig_cause | unit_air_sensor_fail;
        sig_cause = sig_cause | diff_current_dev;
        sig_cause = sig_cause | (|canio_signal);
        sig_cause = sig_cause | insul_warn | signal_cause_ext;
        sack_cause = |stack_temp_fault;
        sack_cause = sack_cause | igbt_air_fault | (|exhaust_air_fault) | unit_air_fault;
        sack_cause = sack_cause | (|sensor_fail);
        sack_cause = sack_cause | insul_alarm_selfack | selfack_cause_ext;
        deact_cause = canio_param_err | insul_alarm_deact | deact_cause_ext | hw_overload;
        causes = inverter_on ? {deact_cause, sack_cause, sig_cause} : 3'h0;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ack_d <= 1'b0;
        end else begin
            ack_d <= manual_ack;
        end
    end
    assign ack_pulse = manual_ack & ~ack_d;

    // Self-acknowledging and signaling flags clear when cause is gone
    ifs_sticky #(
        .N(2)
    ) u_sticky (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .cause(causes[1:0]),
        .auto_clear(2'b11),
        .manual_ack(ack_pulse | ~inverter_on),
        .flag(flags[1:0])
    );

    // Deactivating sequence
    always_ff @(posedge core_clk) begin
        if (sys_rst || !inverter_on) begin
            state_r <= IFS_ST_RUN;
            delay_r <= 32'h0;
            dip_r <= 1'b0;
        end else begin
            case (state_r)
                IFS_ST_RUN: begin
                    if (causes[2]) begin
                        dip_r <= dc_dip_exceeded;
                        delay_r <= 32'h0;
                        if (retry_r == `IFS_MAX_RETRIES) begin
                            state_r <= IFS_ST_PERM;
                        end else begin
                            state_r <= IFS_ST_WAIT;
                        end
                    end
                end
                IFS_ST_WAIT: begin
                    if (dc_dip_exceeded) begin
                        dip_r <= 1'b1;
                    end
                    if (tick) begin
                        delay_r <= delay_r + 32'h1;
                    end
                    if (delay_r >= 32'(RESTART_DELAY_MS)) begin
                        if (dip_r || dc_dip_exceeded) begin
                            state_r <= IFS_ST_PERM;
                        end else begin
                            state_r <= IFS_ST_ATTEMPT;
                        end
                    end
                end
                IFS_ST_ATTEMPT: begin
                    state_r <= IFS_ST_RUN;
                end
                IFS_ST_PERM: begin
                    if (ack_pulse) begin
                        state_r <= IFS_ST_RUN;
                    end
                end
                default: begin
                    state_r <= IFS_ST_RUN;
                end
            endcase
        end
    end

    // Retry counter and its clear after continuous operation
    always_ff @(posedge core_clk) begin
        if (sys_rst || !inverter_on) begin
            retry_r <= 2'h0;
            run_r <= 32'h0;
        end else if (state_r == IFS_ST_ATTEMPT) begin
            retry_r <= retry_r + 2'h1;
            run_r <= 32'h0;
        end else if (state_r == IFS_ST_PERM && ack_pulse) begin
            retry_r <= 2'h0;
        end else if (state_r == IFS_ST_RUN && !causes[2] && retry_r != 2'h0) begin
            if (tick) begin
                run_r <= run_r + 32'h1;
            end
            if (run_r >= 32'(CLEAR_TIME_MS)) begin
                retry_r <= 2'h0;
                run_r <= 32'h0;
            end
        end else begin
            run_r <= 32'h0;
        end
    end

    assign flags[2] = (state_r != IFS_ST_RUN) || causes[2];

    // Registered copies for the operator display and the retry count
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            operator_display_unit <= '0;
            retry_count <= 2'h0;
        end else begin
            retry_count <= retry_r;
            operator_display_unit.deact <= flags[2];
            operator_display_unit.selfack <= flags[1];
            operator_display_unit.signal <= flags[0];
            operator_display_unit.permanent <= (state_r == IFS_ST_PERM);
        end
    end

    // Switching outputs, most severe class wins
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            switches <= '0;
        end else if (hw_overload || flags[2]) begin
            switches <= '0;
        end else if (flags[1]) begin
            switches.ac_output_contactor_closed <= 1'b0;
            switches.dc_load_switch_closed <= 1'b1;
        end else begin
            switches.ac_output_contactor_closed <= inverter_on;
            switches.dc_load_switch_closed <= inverter_on;
        end
    end

    // Reported class; a stale signaling flag is hidden once switched off
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            active_class <= ifs_pkg::IFS_CLS_NONE;
        end else if (hw_overload || flags[2]) begin
            active_class <= ifs_pkg::IFS_CLS_DEACT;
        end else if (flags[1]) begin
            active_class <= ifs_pkg::IFS_CLS_SELFACK;
        end else if (flags[0] && inverter_on) begin
            active_class <= ifs_pkg::IFS_CLS_SIGNAL;
        end else begin
            active_class <= ifs_pkg::IFS_CLS_NONE;
        end
    end
endmodule

// >>> design/ifs_tick.sv
// Millisecond enable pulse divider
module ifs_tick #(
    parameter int DIV = 125000
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    output logic tick
);
    logic [31:0] cnt_r;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt_r <= 32'h0;
            tick <= 1'b0;
        end else if (cnt_r == 32'(DIV - 1)) begin
            cnt_r <= 32'h0;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule

// >>> tb/ifs_supervisor_sva.sv
// Assertion checker for the inverter fault supervisor
module ifs_supervisor_sva (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic inverter_on,
    input wire logic hw_overload,
    input wire logic signal_cause_ext,
    input wire ifs_pkg::ifs_switch_t switches,
    input wire ifs_pkg::ifs_display_t operator_display_unit,
    input wire logic [1:0] retry_count,
    input wire ifs_pkg::ifs_class_t active_class
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence off_held;
        // Flags clear on the first off edge and reach the outputs one edge later
        !inverter_on [*3];
    endsequence
    sequence sig_held;
        inverter_on && signal_cause_ext ##1 inverter_on && signal_cause_ext;
    endsequence
    off_quiet_a: assert property (off_held |-> operator_display_unit == 4'h0 && retry_count == 2'h0)
        else $error("display not clear while switched off");
    overload_open_a: assert property (hw_overload && inverter_on |=> switches == 2'h0)
        else $error("overload left a switch closed");
    selfack_sw_a: assert property (active_class == ifs_pkg::IFS_CLS_SELFACK |-> switches == 2'h1)
        else $error("self-ack switch state wrong");
    signal_sw_a: assert property (active_class == ifs_pkg::IFS_CLS_SIGNAL |-> switches == 2'h3)
        else $error("signaling fault opened a switch");
    deact_sw_a: assert property (active_class == ifs_pkg::IFS_CLS_DEACT |-> switches == 2'h0)
        else $error("deactivating fault left a switch closed");
    retry_step_a: assert property (retry_count != $past(retry_count) |->
        retry_count == $past(retry_count) + 2'h1 || retry_count == 2'h0)
        else $error("retry counter jumped");
    perm_latch_a: assert property (operator_display_unit.permanent |->
        operator_display_unit.deact && switches == 2'h0)
        else $error("permanent shutdown without deactivation");
    signal_flag_a: assert property (sig_held |=> operator_display_unit.signal)
        else $error("signaling flag missing");
    rank_top_a: assert property (operator_display_unit.deact |-> active_class == ifs_pkg::IFS_CLS_DEACT)
        else $error("class below deactivating");
endmodule
bind ifs_supervisor ifs_supervisor_sva u_sva (.*);

// >>> tb/ifs_switchgear_model.sv
// Contactor and load switch model returning contact feedback
module ifs_switchgear_model (
    input wire logic core_clk,
    input wire ifs_pkg::ifs_switch_t switches,
    output logic ac_fb,
    output logic dc_fb
);
    // Contacts follow their coils one cycle late
    always_ff @(posedge core_clk) begin
        ac_fb <= switches.ac_output_contactor_closed;
        dc_fb <= switches.dc_load_switch_closed;
    end
endmodule

// >>> tb/tb.sv
// Self-checking bench for the inverter fault supervisor
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic inverter_on = 1'b1;
    logic manual_ack = 1'b0;
    logic hw_overload = 1'b0;
    logic dc_dip_exceeded = 1'b0;
    logic [24:0] sg = '0;
    logic [12:0] sa = '0;
    logic [2:0] dz = '0;
    ifs_pkg::ifs_switch_t switches;
    ifs_pkg::ifs_display_t operator_display_unit;
    logic [1:0] retry_count;
    ifs_pkg::ifs_class_t active_class;
    logic ac_fb;
    logic dc_fb;
    logic [7:0] obs;
    int num_errors = 0;
    int checks = 0;
    int cyc = 0;
    assign obs = {active_class, switches, operator_display_unit};
    always #4 core_clk = ~core_clk;
    ifs_supervisor #(.RESTART_DELAY_MS(3), .CLEAR_TIME_MS(5), .TICK_DIV(2)) u_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .inverter_on(inverter_on), .manual_ack(manual_ack),
        .stack_temp_warn(sg[1:0]), .stack_temp_fault(sa[1:0]), .igbt_air_under(sg[2]), .igbt_air_warn(sg[3]),
        .igbt_air_fault(sa[2]), .exhaust_air_warn(sg[5:4]), .exhaust_air_fault(sa[4:3]),
        .unit_air_under(sg[6]), .unit_air_warn(sg[7]), .unit_air_fault(sa[5]), .sensor_fail(sa[10:6]),
        .unit_air_sensor_fail(sg[8]), .diff_current_dev(sg[9]), .canio_signal(sg[22:10]),
        .canio_param_err(dz[0]), .insul_warn(sg[23]), .insul_alarm_selfack(sa[11]), .insul_alarm_deact(dz[1]),
        .deact_cause_ext(dz[2]), .selfack_cause_ext(sa[12]), .signal_cause_ext(sg[24]),
        .hw_overload(hw_overload), .dc_dip_exceeded(dc_dip_exceeded), .switches(switches),
        .operator_display_unit(operator_display_unit), .retry_count(retry_count), .active_class(active_class));
    ifs_switchgear_model u_gear (.core_clk(core_clk), .switches(switches), .ac_fb(ac_fb), .dc_fb(dc_fb));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic ack();
        manual_ack = 1'b1;
        wt(1);
        manual_ack = 1'b0;
        wt(4);
    endtask
    task automatic t_signal();
        for (int i = 0; i < 25; i++) begin
            sg[i] = 1'b1;
            wt(3);
            chk("signal raise", obs, 8'h72);
            chk("contacts", {6'h0, ac_fb, dc_fb}, 8'h03);
            sg[i] = 1'b0;
            wt(3);
            chk("signal clear", obs, 8'h30);
        end
        $display("signal test done");
    endtask
    task automatic t_selfack();
        sg[24] = 1'b1;
        for (int i = 0; i < 13; i++) begin
            sa[i] = 1'b1;
            wt(3);
            chk("selfack raise", obs, 8'h96);
            chk("selfack contacts", {6'h0, ac_fb, dc_fb}, 8'h01);
            ack();
            chk("selfack reraise", obs, 8'h96);
            sa[i] = 1'b0;
            wt(3);
            chk("selfack restart", obs, 8'h72);
        end
        sg[24] = 1'b0;
        wt(3);
        $display("selfack test done");
    endtask
    task automatic t_deact();
        dz[0] = 1'b1;
        wt(3);
        chk("deact trip", obs, 8'hC8);
        dz[0] = 1'b0;
        wt(12);
        chk("restart", obs, 8'h30);
        chk("retry one", {6'h0, retry_count}, 8'h01);
        wt(24);
        chk("retry cleared", {6'h0, retry_count}, 8'h00);
        for (int j = 0; j < 3; j++) begin
            dz[j] = 1'b1;
            wt(80);
            chk("perm latch", obs, 8'hC9);
            chk("retry max", {6'h0, retry_count}, 8'h03);
            if (j == 2) begin
                ack();
                chk("deact reraise", obs, 8'hC8);
            end
            dz[j] = 1'b0;
            ack();
            if (j == 2) begin
                wt(12);
            end
            chk("perm ack", obs, 8'h30);
        end
        $display("deact test done");
    endtask
    task automatic t_dip_off();
        dz[0] = 1'b1;
        dc_dip_exceeded = 1'b1;
        wt(4);
        dz[0] = 1'b0;
        wt(12);
        chk("dip no restart", obs, 8'hC9);
        dc_dip_exceeded = 1'b0;
        ack();
        chk("dip ack", obs, 8'h30);
        hw_overload = 1'b1;
        wt(1);
        chk("overload open", {6'h0, switches}, 8'h00);
        hw_overload = 1'b0;
        sg[0] = 1'b1;
        dz[2] = 1'b1;
        inverter_on = 1'b0;
        wt(3);
        chk("off quiet", obs, 8'h00);
        chk("off retry", {6'h0, retry_count}, 8'h00);
        sg[0] = 1'b0;
        dz[2] = 1'b0;
        inverter_on = 1'b1;
        wt(4);
        chk("on again", obs, 8'h30);
        $display("dip and off test done");
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            close_out();
        end
    end
    initial begin
        wt(4);
        sys_rst = 1'b0;
        wt(2);
        chk("idle", obs, 8'h30);
        t_signal();
        t_selfack();
        t_deact();
        t_dip_off();
        close_out();
    end
endmodule
